// ---- dspdma_pkg.sv ----
package dspdma_pkg;

    // Register word indices (byte address is four times the index)
    localparam logic [24:0] VS_HI_IDX     = 25'h1FF828D;
    localparam logic [24:0] VS_LO_IDX     = 25'h1FF828F;
    localparam logic [24:0] STATUS_IDX    = 25'h1FF8280;

    // Scratch-pad parameter locations
    localparam logic [8:0]  ENB_SP_ADDR   = 9'h0F9;
    localparam logic [8:0]  BAH_SP_ADDR   = 9'h0FA;
    localparam logic [8:0]  BAL_SP_ADDR   = 9'h0FB;
    localparam logic [8:0]  SZ_SP_ADDR    = 9'h0FC;
    localparam logic [8:0]  NSR_SP_ADDR   = 9'h0FD;
    localparam logic [8:0]  AST_SP_ADDR   = 9'h0FE;

    // Field positions of the start-trigger and control/base-high words
    localparam int          ENB_IRQ_BIT   = 0;
    localparam int          PROG_BIT      = 12;
    localparam int          CHAN_HI       = 11;
    localparam int          CHAN_LO       = 10;
    localparam int          ADIR_BIT      = 9;
    localparam int          DDIR_BIT      = 8;
    localparam int          BASE_HI_MSB   = 5;
    localparam logic [2:0]  PROG_CHAN     = 3'h4;

    // Video/scan register field layout (counter holds address bits 22:1)
    localparam int          VS_CNT_W      = 22;
    localparam int          VS_HI_W       = 7;
    localparam int          VS_LO_MSB     = 15;

    // Reset values
    localparam logic [15:0] PARAM_RST     = 16'h0000;
    localparam logic [21:0] VS_CNT_RST    = 22'h000000;
    localparam logic [6:0]  VS_HI_RST     = 7'h00;
    localparam logic [31:0] RDATA_RST     = 32'h00000000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ENB  = 4'b0001,
        ST_BAH  = 4'b0010,
        ST_BAL  = 4'b0011,
        ST_SZ   = 4'b0100,
        ST_NSR  = 4'b0101,
        ST_AST  = 4'b0110,
        ST_XFER = 4'b0111,
        ST_DONE = 4'b1000
    } dspdma_state_t;

endpackage : dspdma_pkg

// ---- dspdma_sync.sv ----
`timescale 1ns/1ps
module dspdma_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,      // System clock
    input  wire logic         nrst,     // Synchronous reset, active low
    input  wire logic [W-1:0] async_in, // Level from another domain
    output logic      [W-1:0] sync_out  // Level safe to use
);
    logic [W-1:0] meta;

    // Two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule : dspdma_sync

// ---- dspdma_addr_gen.sv ----
// Function
// - Bit 12 set selects program DMA channel 4, clear selects data channels 0-3.
// - For data DMA bits 11-10 pick the channel; ignored for program DMA.
// - Address bit 9 zero increments, one decrements, after each halfword except the last of a block.
// - Bit 8 zero reads the scratch pad, one writes into it.
// - Base address is control bits 5-0 joined with the 16 base-low bits.
// - Base-low and step are fetched only for an enabled start.
// - Each block moves block-length value plus one halfwords.
// - Zero block length means misconfigured; stop fetching, do not transfer.
// - Blocks moved are sub-range count plus one; zero gives one block.
// - Next block starts at last address plus one plus the step.
// - High address write waits inactive until the low address is written.
// - Low address write loads the counter from held high and written low.
// - Reads of both address registers return the live counter.
// - High register bits 6-0 carry address bits 22-16; rest unused.
// - Low register bits 15-1 carry address bits 15-1; bit 0 unused.
// - A rising start pulse begins fetch; transfer and completion interrupt follow only for start-trigger LSB zero and nonzero block length.
// - Start-trigger LSB one raises host interrupt; zero starts the transfer.
// - Parameters come from fixed scratch-pad locations 0xF9 to 0xFE.
`timescale 1ns/1ps
module dspdma_addr_gen #(
    parameter int ADDR_W = 22,   // Halfword address width
    parameter int LEN_W  = 16    // Width of length, count and step words
) (
    input  wire logic              clk,             // 20 MHz system clock
    input  wire logic              nrst,            // Synchronous reset, active low
    input  wire logic [24:0]       avs_address,     // Avalon word address
    input  wire logic              avs_read,        // Avalon read
    input  wire logic              avs_write,       // Avalon write
    input  wire logic [31:0]       avs_writedata,   // Avalon write data
    output logic      [31:0]       avs_readdata,    // Avalon read data
    output logic                   avs_waitrequest, // Avalon wait
    input  wire logic              start_pin,       // Subsystem start pulse pin
    output logic                   sp_rd_req,       // Parameter read request
    output logic      [8:0]        sp_addr,         // Parameter location
    input  wire logic [15:0]       sp_rd_data,      // Parameter word
    input  wire logic              sp_rd_valid,     // Parameter word valid
    output logic                   xfer_req,        // Halfword transfer request
    output logic      [ADDR_W-1:0] xfer_addr,       // Halfword address
    output logic      [2:0]        xfer_chan,       // Logical channel
    output logic                   xfer_to_sp,      // Data goes into scratch pad
    input  wire logic              xfer_ack,        // Halfword done
    output logic                   host_irq,        // Host interrupt pulse
    output logic                   sp_done_irq,     // Completion pulse to subsystem
    output logic                   cfg_error,       // Zero block length seen
    input  wire logic              vs_advance,      // Video/scan counter step
    output logic      [21:0]       vs_addr          // Video/scan address 22:1
);
    dspdma_pkg::dspdma_state_t state;
    dspdma_pkg::dspdma_state_t next_state;

    logic [15:0]       ctrl_word;
    logic [15:0]       base_low;
    logic [LEN_W-1:0]  blk_len;
    logic [LEN_W-1:0]  nsr_cnt;
    logic [LEN_W-1:0]  step;
    logic [LEN_W-1:0]  beat_cnt;
    logic [LEN_W-1:0]  blk_cnt;
    logic [6:0]        vs_hi_hold;
    logic              start_sync;
    logic              start_prev;

    // Start pin synchronised before edge detection
    dspdma_sync #(
        .W (1)
    ) u_start_sync (
        .clk      (clk),
        .nrst     (nrst),
        .async_in (start_pin),
        .sync_out (start_sync)
    );

    always_ff @(posedge clk) begin
        if (!nrst) start_prev <= 1'b0;
        else       start_prev <= start_sync;
    end

    // Decoded conditions
    wire start_rise   = start_sync & ~start_prev;
    wire enb_irq      = sp_rd_data[dspdma_pkg::ENB_IRQ_BIT];
    wire sz_zero      = (sp_rd_data == dspdma_pkg::PARAM_RST);
    wire last_beat    = (beat_cnt == blk_len);
    wire last_block   = (blk_cnt == nsr_cnt);
    wire beat_done    = (state == dspdma_pkg::ST_XFER) & xfer_ack;
    wire addr_down    = ctrl_word[dspdma_pkg::ADIR_BIT];
    wire prog_sel     = ctrl_word[dspdma_pkg::PROG_BIT];
    wire [2:0] chan_sel = prog_sel ? dspdma_pkg::PROG_CHAN
                        : {1'b0, ctrl_word[dspdma_pkg::CHAN_HI:dspdma_pkg::CHAN_LO]};
    wire [ADDR_W-1:0] base_addr = ADDR_W'({ctrl_word[dspdma_pkg::BASE_HI_MSB:0], base_low});
    wire [ADDR_W-1:0] addr_inc  = ADDR_W'(xfer_addr + ADDR_W'(1));
    wire [ADDR_W-1:0] addr_dec  = ADDR_W'(xfer_addr - ADDR_W'(1));
    wire [ADDR_W-1:0] addr_jump = ADDR_W'(addr_inc + ADDR_W'(step));
    wire is_fetch = (next_state == dspdma_pkg::ST_ENB) | (next_state == dspdma_pkg::ST_BAH) |
                    (next_state == dspdma_pkg::ST_BAL) | (next_state == dspdma_pkg::ST_SZ)  |
                    (next_state == dspdma_pkg::ST_NSR) | (next_state == dspdma_pkg::ST_AST);

    // Parameter location for the coming fetch
    // fixed parameter locations
    wire [8:0] next_sp_addr =
        (next_state == dspdma_pkg::ST_ENB) ? dspdma_pkg::ENB_SP_ADDR :
        (next_state == dspdma_pkg::ST_BAH) ? dspdma_pkg::BAH_SP_ADDR :
        (next_state == dspdma_pkg::ST_BAL) ? dspdma_pkg::BAL_SP_ADDR :
        (next_state == dspdma_pkg::ST_SZ)  ? dspdma_pkg::SZ_SP_ADDR  :
        (next_state == dspdma_pkg::ST_NSR) ? dspdma_pkg::NSR_SP_ADDR :
        dspdma_pkg::AST_SP_ADDR;

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            // rising start pulse opens a transfer
            dspdma_pkg::ST_IDLE: begin
                if (start_rise) next_state = dspdma_pkg::ST_ENB;
            end
            // trigger LSB picks interrupt or transfer
            // enabled starts only go on to fetch more
            dspdma_pkg::ST_ENB: begin
                if (sp_rd_valid) next_state = enb_irq ? dspdma_pkg::ST_IDLE : dspdma_pkg::ST_BAH;
            end
            dspdma_pkg::ST_BAH: begin
                if (sp_rd_valid) next_state = dspdma_pkg::ST_BAL;
            end
            dspdma_pkg::ST_BAL: begin
                if (sp_rd_valid) next_state = dspdma_pkg::ST_SZ;
            end
            dspdma_pkg::ST_SZ: begin
                if (sp_rd_valid) next_state = sz_zero ? dspdma_pkg::ST_IDLE : dspdma_pkg::ST_NSR;
            end
            dspdma_pkg::ST_NSR: begin
                if (sp_rd_valid) next_state = dspdma_pkg::ST_AST;
            end
            dspdma_pkg::ST_AST: begin
                if (sp_rd_valid) next_state = dspdma_pkg::ST_XFER;
            end
            dspdma_pkg::ST_XFER: begin
                if (beat_done && last_beat && last_block) next_state = dspdma_pkg::ST_DONE;
            end
            dspdma_pkg::ST_DONE: begin
                next_state = dspdma_pkg::ST_IDLE;
            end
            default: begin
                next_state = dspdma_pkg::ST_IDLE;
            end
        endcase
    end

    // State and fetch request
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state     <= dspdma_pkg::ST_IDLE;
            sp_rd_req <= 1'b0;
            sp_addr   <= dspdma_pkg::ENB_SP_ADDR;
        end else begin
            state     <= next_state;
            sp_rd_req <= is_fetch;
            sp_addr   <= next_sp_addr;
        end
    end

    // Parameter capture
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_word <= dspdma_pkg::PARAM_RST;
            base_low  <= dspdma_pkg::PARAM_RST;
            blk_len   <= LEN_W'(dspdma_pkg::PARAM_RST);
            nsr_cnt   <= LEN_W'(dspdma_pkg::PARAM_RST);
            step      <= LEN_W'(dspdma_pkg::PARAM_RST);
        end else if (sp_rd_valid) begin
            if (state == dspdma_pkg::ST_BAH) ctrl_word <= sp_rd_data;
            if (state == dspdma_pkg::ST_BAL) base_low  <= sp_rd_data;
            if (state == dspdma_pkg::ST_SZ)  blk_len   <= LEN_W'(sp_rd_data);
            if (state == dspdma_pkg::ST_NSR) nsr_cnt   <= LEN_W'(sp_rd_data);
            if (state == dspdma_pkg::ST_AST) step      <= LEN_W'(sp_rd_data);
        end
    end

    // Beat and block counters
    // length plus one beats per block
    always_ff @(posedge clk) begin
        if (!nrst || state == dspdma_pkg::ST_AST) begin
            beat_cnt <= '0;
            blk_cnt  <= '0;
        end else if (beat_done) begin
            beat_cnt <= last_beat ? '0 : LEN_W'(beat_cnt + LEN_W'(1));
            if (last_beat) blk_cnt <= LEN_W'(blk_cnt + LEN_W'(1));
        end
    end

    // Transfer address generation
    always_ff @(posedge clk) begin
        if (!nrst) begin
            xfer_addr <= '0;
        end else if (state == dspdma_pkg::ST_AST && sp_rd_valid) begin
            // base from high and low parts
            xfer_addr <= base_addr;
        end else if (beat_done) begin
            // jump by step at block end
            // step up or down per halfword
            if (last_beat)      xfer_addr <= addr_jump;
            else if (addr_down) xfer_addr <= addr_dec;
            else                xfer_addr <= addr_inc;
        end
    end

    // Transfer shape outputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            xfer_req   <= 1'b0;
            xfer_chan  <= 3'h0;
            xfer_to_sp <= 1'b0;
        end else begin
            xfer_req   <= (next_state == dspdma_pkg::ST_XFER);
            // channel field used only for data
            xfer_chan  <= chan_sel;
            xfer_to_sp <= ctrl_word[dspdma_pkg::DDIR_BIT];
        end
    end

    // Interrupt pulses and configuration error
    always_ff @(posedge clk) begin
        if (!nrst) begin
            host_irq    <= 1'b0;
            sp_done_irq <= 1'b0;
            cfg_error   <= 1'b0;
        end else begin
            host_irq    <= (state == dspdma_pkg::ST_ENB) & sp_rd_valid & enb_irq;
            sp_done_irq <= (state == dspdma_pkg::ST_DONE);
            if (state == dspdma_pkg::ST_SZ && sp_rd_valid && sz_zero) cfg_error <= 1'b1;
            else if (start_rise && state == dspdma_pkg::ST_IDLE)      cfg_error <= 1'b0;
        end
    end

    // Avalon decode
    wire bus_req  = avs_read | avs_write;
    wire wr_take  = avs_write & ~avs_waitrequest;
    wire rd_take  = avs_read & avs_waitrequest;
    wire hit_hi   = (avs_address == dspdma_pkg::VS_HI_IDX);
    wire hit_lo   = (avs_address == dspdma_pkg::VS_LO_IDX);
    wire hit_st   = (avs_address == dspdma_pkg::STATUS_IDX);
    wire [31:0] rd_hi = {25'h0000000, vs_addr[dspdma_pkg::VS_CNT_W-1:dspdma_pkg::VS_LO_MSB]};
    wire [31:0] rd_lo = {16'h0000, vs_addr[dspdma_pkg::VS_LO_MSB-1:0], 1'b0};
    wire [31:0] rd_st = {23'h000000, cfg_error, xfer_chan, 1'b0, state};
    wire [31:0] rd_mux;
    assign rd_mux = hit_hi ? rd_hi :
                    hit_lo ? rd_lo :
                    hit_st ? rd_st : dspdma_pkg::RDATA_RST;

    // Wait state generation and read data
    always_ff @(posedge clk) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= dspdma_pkg::RDATA_RST;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (rd_take) avs_readdata <= rd_mux;
        end
    end

    // Video/scan start address counter
    always_ff @(posedge clk) begin
        if (!nrst) begin
            vs_hi_hold <= dspdma_pkg::VS_HI_RST;
            vs_addr    <= dspdma_pkg::VS_CNT_RST;
        end else begin
            if (wr_take && hit_hi) vs_hi_hold <= avs_writedata[dspdma_pkg::VS_HI_W-1:0];
            if (wr_take && hit_lo)
                vs_addr <= {vs_hi_hold, avs_writedata[dspdma_pkg::VS_LO_MSB:1]};
            else if (vs_advance)
                vs_addr <= 22'(vs_addr + 22'h000001);
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_enb_irq_path: assert property (
        (state == dspdma_pkg::ST_ENB && sp_rd_valid && enb_irq)
        |=> (host_irq && state == dspdma_pkg::ST_IDLE && !sp_rd_req))
        else $error("trigger LSB did not raise host interrupt");

    a_sz_zero_stop: assert property (
        (state == dspdma_pkg::ST_SZ && sp_rd_valid && sz_zero)
        |=> (state == dspdma_pkg::ST_IDLE && cfg_error) ##1 !xfer_req)
        else $error("zero block length did not stop the channel");

    a_fetch_order: assert property (
        (state == dspdma_pkg::ST_BAH && sp_rd_valid)
        |=> (state == dspdma_pkg::ST_BAL && sp_rd_req && sp_addr == dspdma_pkg::BAL_SP_ADDR))
        else $error("base-low fetch did not follow control fetch");

    a_addr_step: assert property (
        (beat_done && !last_beat)
        |=> xfer_addr == ($past(addr_down) ? ADDR_W'($past(xfer_addr) - ADDR_W'(1))
                                           : ADDR_W'($past(xfer_addr) + ADDR_W'(1))))
        else $error("address did not move by one halfword");

    a_block_jump: assert property (
        (beat_done && last_beat && !last_block)
        |=> xfer_addr == ADDR_W'($past(xfer_addr) + ADDR_W'(1) + ADDR_W'($past(step))))
        else $error("block start address wrong");

    a_base_load: assert property (
        (state == dspdma_pkg::ST_AST && sp_rd_valid)
        |=> (xfer_req && xfer_addr == ADDR_W'({$past(ctrl_word[5:0]), $past(base_low)})))
        else $error("base address not formed from both parts");

    a_chan_sel: assert property (
        xfer_req |-> xfer_chan == (ctrl_word[dspdma_pkg::PROG_BIT] ? dspdma_pkg::PROG_CHAN
                                   : {1'b0, ctrl_word[11:10]}))
        else $error("logical channel selection wrong");

    a_data_dir: assert property (
        xfer_req |-> xfer_to_sp == ctrl_word[dspdma_pkg::DDIR_BIT])
        else $error("data direction wrong");

    a_done_irq: assert property (
        (beat_done && last_beat && last_block)
        |=> !xfer_req ##1 (sp_done_irq && state == dspdma_pkg::ST_IDLE))
        else $error("completion interrupt missing after last block");

    a_vs_load: assert property (
        (wr_take && hit_lo)
        |=> vs_addr == {$past(vs_hi_hold), $past(avs_writedata[15:1])})
        else $error("low write did not load the counter");

    a_vs_hold: assert property (
        (wr_take && hit_hi && !vs_advance) |=> vs_addr == $past(vs_addr))
        else $error("high write changed the counter");

endmodule : dspdma_addr_gen

// ---- dspdma_sp_model.sv ----
`timescale 1ns/1ps
// Scratch-pad parameter source and memory-side acknowledge
module dspdma_sp_model (
    input  wire logic        clk,         // System clock
    input  wire logic        nrst,        // Synchronous reset, active low
    input  wire logic        slow,        // Stretch every answer
    input  wire logic        sp_rd_req,   // Parameter fetch wanted
    input  wire logic [8:0]  sp_addr,     // Parameter location
    output logic      [15:0] sp_rd_data,  // Parameter word
    output logic             sp_rd_valid, // Word valid pulse
    input  wire logic        xfer_req,    // Halfword wanted
    output logic             xfer_ack     // Halfword done
);
    logic [15:0] mem [0:5]; // Words for locations 0xF9 to 0xFE
    logic [1:0]  wait_cnt;  // Cycles waited on current fetch

    always @(posedge clk) begin
        sp_rd_valid <= 1'b0;
        // Idle data line toggles so a stale word is never mistaken for valid
        sp_rd_data  <= ~sp_rd_data;
        // Slow memory acknowledges every other cycle
        xfer_ack    <= xfer_req && !(slow && xfer_ack);
        if (!nrst) begin
            wait_cnt   <= 2'h0;
            sp_rd_data <= 16'h0000;
            xfer_ack   <= 1'b0;
        end else if (sp_rd_req && !sp_rd_valid) begin
            if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
                sp_rd_valid <= 1'b1;
                sp_rd_data  <= mem[3'(sp_addr - 9'h0F9)];
                wait_cnt    <= 2'h0;
            end else begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
endmodule : dspdma_sp_model

// ---- dspdma_addr_gen_bench.sv ----
`timescale 1ns/1ps
module dspdma_addr_gen_bench;
    logic        clk, nrst, avs_read, avs_write, avs_waitrequest, start_pin, sp_rd_req;
    logic        sp_rd_valid, xfer_req, xfer_to_sp, xfer_ack, host_irq, sp_done_irq;
    logic        cfg_error, vs_advance, slow;
    logic [24:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [8:0]  sp_addr;
    logic [15:0] sp_rd_data;
    logic [21:0] xfer_addr, vs_addr;
    logic [2:0]  xfer_chan;
    int          errors, samples_checked;
    logic [31:0] st_word;

    dspdma_addr_gen i_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .start_pin(start_pin), .sp_rd_req(sp_rd_req), .sp_addr(sp_addr),
        .sp_rd_data(sp_rd_data), .sp_rd_valid(sp_rd_valid), .xfer_req(xfer_req),
        .xfer_addr(xfer_addr), .xfer_chan(xfer_chan), .xfer_to_sp(xfer_to_sp),
        .xfer_ack(xfer_ack), .host_irq(host_irq), .sp_done_irq(sp_done_irq),
        .cfg_error(cfg_error), .vs_advance(vs_advance), .vs_addr(vs_addr));

    dspdma_sp_model i_sp (.clk(clk), .nrst(nrst), .slow(slow), .sp_rd_req(sp_rd_req),
        .sp_addr(sp_addr), .sp_rd_data(sp_rd_data), .sp_rd_valid(sp_rd_valid),
        .xfer_req(xfer_req), .xfer_ack(xfer_ack));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One Avalon access, held until waitrequest is sampled low
    task automatic avs_rw(input logic wr, input logic [24:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
        int k;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= !wr;
        avs_write     <= wr;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 20) begin
            errors++;
            print_verdict();
        end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : avs_rw

    task automatic reg_checks;
        logic [31:0] rd;
        avs_rw(1'b0, dspdma_pkg::VS_HI_IDX, 32'h0, rd);
        check("high reset", rd, 32'h0);
        avs_rw(1'b1, dspdma_pkg::VS_HI_IDX, 32'hFFFFFF92, rd);
        avs_rw(1'b0, dspdma_pkg::VS_HI_IDX, 32'h0, rd);
        check("high before low", rd, 32'h0);
        check("counter before low", 32'(vs_addr), 32'h0);
        avs_rw(1'b1, dspdma_pkg::VS_LO_IDX, 32'hFFFF3457, rd);
        @(posedge clk);
        check("counter load", 32'(vs_addr), 32'h00091A2B);
        avs_rw(1'b0, dspdma_pkg::VS_HI_IDX, 32'h0, rd);
        check("high read", rd, 32'h00000012);
        @(posedge clk);
        vs_advance <= 1'b1;
        @(posedge clk);
        vs_advance <= 1'b0;
        avs_rw(1'b0, dspdma_pkg::VS_LO_IDX, 32'h0, rd);
        check("low live read", rd, 32'h00003458);
        avs_rw(1'b1, 25'h0000010, 32'hFFFFFFFF, rd);
        avs_rw(1'b0, 25'h0000010, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
        check("counter kept", 32'(vs_addr), 32'h00091A2C);
    endtask : reg_checks

    // one logical transfer, watching fetches and halfwords
    task automatic run_dma(input logic [15:0] start_trigger_param, ctrl_and_base_high_param, base_low_param, sz, subrange_count_param, ast,
                           input logic slow_in);
        logic [8:0]  fq[$];
        logic [21:0] exp_a;
        logic [2:0]  ch;
        int          k, n, hw, left, n_host, n_done, n_fetch;
        exp_a = {ctrl_and_base_high_param[5:0], base_low_param};
        ch = ctrl_and_base_high_param[12] ? 3'h4 : {1'b0, ctrl_and_base_high_param[11:10]};
        n = 0;
        hw = 0;
        left = 0;
        n_host = 0;
        n_done = 0;
        i_sp.mem = '{start_trigger_param, ctrl_and_base_high_param, base_low_param, sz, subrange_count_param, ast};
        slow <= slow_in;
        @(posedge clk);
        start_pin <= 1'b1;
        repeat (2) @(posedge clk);
        start_pin <= 1'b0;
        for (k = 0; k < 400 && left != 1; k++) begin
            @(posedge clk);
            if (sp_rd_req && sp_rd_valid) fq.push_back(sp_addr);
            if (xfer_req && xfer_ack) begin
                check("xfer_addr", 32'(xfer_addr), 32'(exp_a));
                check("xfer_chan", 32'(xfer_chan), 32'(ch));
                check("xfer_to_sp", 32'(xfer_to_sp), 32'(ctrl_and_base_high_param[8]));
                n++;
                hw++;
                if (hw == int'(sz) + 1) begin
                    hw = 0;
                    exp_a = exp_a + 22'h1 + 22'(ast);
                end else begin
                    exp_a = ctrl_and_base_high_param[9] ? exp_a - 22'h1 : exp_a + 22'h1;
                end
            end
            n_host += int'(host_irq === 1'b1);
            n_done += int'(sp_done_irq === 1'b1);
            if (left > 1) left--;
            // A flag left over from the previous run must not end this one
            if (left == 0 && (sp_done_irq || host_irq || (cfg_error && fq.size() == 4)))
                left = 8;
        end
        if (left != 1) begin
            errors++;
            print_verdict();
        end
        n_fetch = start_trigger_param[0] ? 1 : (sz == 16'h0) ? 4 : 6;
        check("fetch count", 32'(fq.size()), 32'(n_fetch));
        for (k = 0; k < fq.size() && k < n_fetch; k++)
            check("fetch addr", 32'(fq[k]), 32'(9'h0F9 + 9'(k)));
        if (start_trigger_param[0] || sz == 16'h0) n_fetch = 0;
        else n_fetch = (int'(sz) + 1) * (int'(subrange_count_param) + 1);
        check("halfwords", 32'(n), 32'(n_fetch));
        check("done pulses", 32'(n_done), 32'(n_fetch != 0));
        check("host pulses", 32'(n_host), 32'(start_trigger_param[0]));
        check("cfg_error", 32'(cfg_error), 32'(!start_trigger_param[0] && sz == 16'h0));
    endtask : run_dma

    initial begin
        nrst = 1'b0;
        avs_address = 25'h0;
        avs_writedata = 32'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        start_pin = 1'b0;
        vs_advance = 1'b0;
        slow = 1'b0;
        errors = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        reg_checks();
        run_dma(16'h0000, 16'h082A, 16'h1234, 16'h0002, 16'h0001, 16'h0005, 1'b0);
        run_dma(16'h0000, 16'h1F3F, 16'h0001, 16'h0001, 16'h0001, 16'hFFFF, 1'b1);
        run_dma(16'h0001, 16'h0000, 16'h0000, 16'h0003, 16'h0000, 16'h0000, 1'b0);
        run_dma(16'h0000, 16'h0100, 16'h0040, 16'h0000, 16'h0007, 16'h0003, 1'b1);
        avs_rw(1'b0, dspdma_pkg::STATUS_IDX, 32'h0, st_word);
        check("status", st_word, 32'h00000100);
        // All four data channel codes, alternating direction
        for (int c = 0; c < 4; c++)
            run_dma(16'h0000, 16'(c * 16'h0500), 16'h0100, 16'h0001, 16'h0000,
                    16'h0000, 1'b0);
        print_verdict();
    end
endmodule : dspdma_addr_gen_bench
